/* logic/eic_top.sv */
/*
 * Edge interval counter block: two interval counters, reference clock
 * selection and drive-out, scan and output rate generators, and the
 * counter words appended to the analog input sample stream.
 * Assumes an Avalon-MM master on clk, and a sequencer that pulses
 * scan_start and conv_done; tach, gate and the trigger line are
 * asynchronous pins.
 */
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "eic_map.svh"

// Contract
// - Two independent 32-bit counters measure frequency, period or phase.
// - Each counter has its own enable and only an enabled counter enters the stream.
// - A measurement starts on a chosen event: conversion done, tach or gate edge.
// - A measurement stops on a separately chosen event from the same five.
// - With read-and-clear set, the reported value is zeroed between measurements.
// - Without read-and-clear, the previous result stays until the next completes.
// - Counter values are aligned with the analog samples of the same scan.
// - Counters follow the same triggers and clocks as the analog input channels.
// - A requested scan rate is rounded to the nearest achievable and reported.
// - A requested output rate is rounded to the nearest achievable and reported.
// - The reference clock is internal by default or taken from trigger line seven.
// - The clock is driven out on trigger line seven only when enabled.
module eic_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // measurement pins and sequencer events
    input wire logic tach_in,
    input wire logic gate_in,
    input wire logic conv_done,
    input wire logic scan_start,
    // trigger bus line seven, three-signal pin
    input wire logic lxi7_in,
    output logic lxi7_out,
    output logic lxi7_oe,
    // rate strobes and reference selection
    output logic scan_tick,
    output logic out_tick,
    output logic ref_ext,
    // counter words toward the sample stream
    output logic [31:0] strm_data,
    output logic strm_valid,
    output logic strm_chan
);

    // synchronisers for asynchronous pins
    logic [1:0] tach_s_q, gate_s_q, lxi_s_q;
    logic tach_d_q, gate_d_q, lxi_d_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tach_s_q <= 2'h0;
            gate_s_q <= 2'h0;
            lxi_s_q <= 2'h0;
            tach_d_q <= 1'b0;
            gate_d_q <= 1'b0;
            lxi_d_q <= 1'b0;
        end else begin
            tach_s_q <= {tach_s_q[0], tach_in};
            gate_s_q <= {gate_s_q[0], gate_in};
            lxi_s_q <= {lxi_s_q[0], lxi7_in};
            tach_d_q <= tach_s_q[1];
            gate_d_q <= gate_s_q[1];
            lxi_d_q <= lxi_s_q[1];
        end
    end

    // edge strobes indexed by event code
    wire logic tach_rise = tach_s_q[1] && !tach_d_q;
    wire logic tach_fall = !tach_s_q[1] && tach_d_q;
    wire logic gate_rise = gate_s_q[1] && !gate_d_q;
    wire logic gate_fall = !gate_s_q[1] && gate_d_q;
    wire logic [4:0] events = {gate_rise, gate_fall, tach_rise, tach_fall, conv_done};

    // registers
    logic [31:0] ctrl_q, clk_q, scan_div_q, out_div_q;
    logic [31:0] scan_cnt_q, out_cnt_q;
    logic [31:0] rdata_q;
    logic wait_q;

    // word write with byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // nearest divisor: requested rate in Hz, round half up, clamp at minimum
    function automatic logic [31:0] rate_div(input logic [31:0] hz);
        logic [63:0] q;
        q = 64'(`EIC_CLK_HZ) + {33'h0, hz[31:1]};
        q = (hz == 32'h0000_0000) ? 64'(`EIC_DIV_RST) : q / {32'h0, hz};
        return (q < 64'(`EIC_DIV_MIN)) ? `EIC_DIV_MIN : q[31:0];
    endfunction

    // achieved rate from a divisor, rounded to nearest Hz
    function automatic logic [31:0] div_rate(input logic [31:0] dv);
        logic [63:0] q;
        q = (64'(`EIC_CLK_HZ) + {33'h0, dv[31:1]}) / {32'h0, dv};
        return q[31:0];
    endfunction

    // address decode, one cycle of wait before each answer
    wire logic acc = (avs_read || avs_write) && wait_q;
    wire logic wr = avs_write && !wait_q;
    wire logic sel_ctrl = avs_address == `EIC_CTRL_OFS;
    wire logic sel_clk = avs_address == `EIC_CLK_OFS;
    wire logic sel_scan = avs_address == `EIC_SCAN_REQ_OFS;
    wire logic sel_out = avs_address == `EIC_OUT_REQ_OFS;
    wire logic [31:0] scan_req = be_merge(div_rate(scan_div_q), avs_writedata, avs_byteenable);
    wire logic [31:0] out_req = be_merge(div_rate(out_div_q), avs_writedata, avs_byteenable);

    logic [31:0] cnt_val [2];
    logic [1:0] cnt_fresh;
    logic [31:0] rd_mux;
    always_comb begin
        if (sel_ctrl) begin
            rd_mux = ctrl_q;
        end else if (sel_clk) begin
            rd_mux = clk_q;
        end else if (sel_scan || avs_address == `EIC_SCAN_ACT_OFS) begin
            rd_mux = div_rate(scan_div_q);
        end else if (sel_out || avs_address == `EIC_OUT_ACT_OFS) begin
            rd_mux = div_rate(out_div_q);
        end else if (avs_address == `EIC_CNT0_OFS) begin
            rd_mux = cnt_val[0];
        end else if (avs_address == `EIC_CNT1_OFS) begin
            rd_mux = cnt_val[1];
        end else if (avs_address == `EIC_STAT_OFS) begin
            rd_mux = {30'h0, cnt_fresh};
        end else begin
            rd_mux = 32'h0000_0000; // unmapped reads zero, writes dropped
        end
    end

    // bus registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            ctrl_q <= `EIC_CTRL_RST;
            clk_q <= `EIC_CLK_RST;
            scan_div_q <= `EIC_DIV_RST;
            out_div_q <= `EIC_DIV_RST;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
            if (acc) begin
                rdata_q <= rd_mux;
            end
            if (wr && sel_ctrl) begin
                ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
            end
            if (wr && sel_clk) begin
                clk_q <= be_merge(clk_q, avs_writedata, avs_byteenable);
            end
            if (wr && sel_scan) begin
                scan_div_q <= rate_div(scan_req);
            end
            if (wr && sel_out) begin
                out_div_q <= rate_div(out_req);
            end
        end
    end

    // reference source: internal ticks, or rising edges of line seven
    wire logic ext_sel = clk_q[`EIC_REF_SEL_BIT];
    wire logic tick = ext_sel ? (lxi_s_q[1] && !lxi_d_q) : 1'b1;

    // rate generators from the selected reference
    logic scan_t_q, out_t_q, div_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_cnt_q <= 32'h0000_0000;
            out_cnt_q <= 32'h0000_0000;
            scan_t_q <= 1'b0;
            out_t_q <= 1'b0;
            div_q <= 1'b0;
        end else begin
            scan_t_q <= 1'b0;
            out_t_q <= 1'b0;
            div_q <= !div_q;
            if (tick) begin
                scan_cnt_q <= scan_cnt_q + 32'h0000_0001;
                out_cnt_q <= out_cnt_q + 32'h0000_0001;
                if (scan_cnt_q + 32'h0000_0001 >= scan_div_q) begin
                    scan_cnt_q <= 32'h0000_0000;
                    scan_t_q <= 1'b1;
                end
                if (out_cnt_q + 32'h0000_0001 >= out_div_q) begin
                    out_cnt_q <= 32'h0000_0000;
                    out_t_q <= 1'b1;
                end
            end
        end
    end

    // clock drive-out; a half-rate copy, since clk itself cannot leave a flop
    logic oe_q, ext_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
            ext_q <= 1'b0;
        end else begin
            // never drive a line we are also listening to
            oe_q <= clk_q[`EIC_CLK_OUT_BIT] && !ext_sel;
            ext_q <= ext_sel;
        end
    end

    // two counter channels
    logic [1:0] take;
    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            eic_channel u_ch (
                .clk(clk),
                .rst_n(rst_n),
                .enable(ctrl_q[c*`EIC_CH_STRIDE + `EIC_EN_BIT]),
                .read_clear(ctrl_q[c*`EIC_CH_STRIDE + `EIC_RC_BIT]),
                .start_sel(eic_pkg::eic_event_t'(ctrl_q[c*`EIC_CH_STRIDE + `EIC_START_LSB +: 3])),
                .stop_sel(eic_pkg::eic_event_t'(ctrl_q[c*`EIC_CH_STRIDE + `EIC_STOP_LSB +: 3])),
                .events(events),
                .tick(tick),
                .sample_take(take[c]),
                .value(cnt_val[c]),
                .fresh(cnt_fresh[c])
            );
        end
    endgenerate

    // stream: on each scan start of the analog sequencer, snapshot both
    // values at once so they belong to that scan, then emit enabled ones
    logic [31:0] snap_q [2];
    logic [1:0] pend_q;
    logic [31:0] sdata_q;
    logic svalid_q, schan_q;
    wire logic [1:0] en_v = {ctrl_q[`EIC_CH_STRIDE + `EIC_EN_BIT], ctrl_q[`EIC_EN_BIT]};
    assign take = scan_start ? en_v : 2'b00;
    wire logic pick = !pend_q[0];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_q[0] <= 32'h0000_0000;
            snap_q[1] <= 32'h0000_0000;
            pend_q <= 2'b00;
            sdata_q <= 32'h0000_0000;
            svalid_q <= 1'b0;
            schan_q <= 1'b0;
        end else begin
            svalid_q <= 1'b0;
            if (scan_start) begin
                snap_q[0] <= cnt_val[0];
                snap_q[1] <= cnt_val[1];
                pend_q <= en_v;
            end else if (pend_q != 2'b00) begin
                sdata_q <= snap_q[pick];
                schan_q <= pick;
                svalid_q <= 1'b1;
                pend_q[pick] <= 1'b0;
            end
        end
    end

    // outputs straight from flops
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign lxi7_out = div_q;
    assign lxi7_oe = oe_q;
    assign scan_tick = scan_t_q;
    assign out_tick = out_t_q;
    assign ref_ext = ext_q;
    assign strm_data = sdata_q;
    assign strm_valid = svalid_q;
    assign strm_chan = schan_q;

endmodule

/* logic/eic_map.svh */
/*
 * Register offsets, field positions, reset values and timing constants
 * for the edge interval counter block.
 * Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
 */
`ifndef EIC_MAP_SVH
`define EIC_MAP_SVH

// register byte offsets
`define EIC_CTRL_OFS 6'h00
`define EIC_CLK_OFS 6'h04
`define EIC_SCAN_REQ_OFS 6'h08
`define EIC_SCAN_ACT_OFS 6'h0C
`define EIC_OUT_REQ_OFS 6'h10
`define EIC_OUT_ACT_OFS 6'h14
`define EIC_CNT0_OFS 6'h18
`define EIC_CNT1_OFS 6'h1C
`define EIC_STAT_OFS 6'h20

// control fields, one byte per counter
`define EIC_CH_STRIDE 8
`define EIC_EN_BIT 0
`define EIC_RC_BIT 1
`define EIC_START_LSB 2
`define EIC_STOP_LSB 5
`define EIC_CTRL_RST 32'h0000_0000

// clock register fields
`define EIC_REF_SEL_BIT 0
`define EIC_CLK_OUT_BIT 1
`define EIC_CLK_RST 32'h0000_0000

// rate generator: divisor of the 40 MHz time base
`define EIC_CLK_HZ 40000000
`define EIC_DIV_MIN 32'h0000_0028
`define EIC_DIV_RST 32'h0000_9C40

`endif

/* logic/eic_pkg.sv */
/*
 * Types shared by the edge interval counter block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package eic_pkg;

    // measurement edge selection
    typedef enum logic [2:0] {
        EIC_EV_CONV = 3'b000,
        EIC_EV_TACH_FALL = 3'b001,
        EIC_EV_TACH_RISE = 3'b010,
        EIC_EV_GATE_FALL = 3'b011,
        EIC_EV_GATE_RISE = 3'b100
    } eic_event_t;

    // per-counter measurement state
    typedef enum logic [1:0] {
        EIC_ARMED = 2'b00,
        EIC_COUNTING = 2'b01
    } eic_meas_t;

endpackage

/* logic/eic_channel.sv */
/*
 * One 32-bit interval counter: counts reference ticks from a start
 * event to a stop event and latches the result.
 * Assumes event strobes are one-cycle pulses in the clk domain.
 */
`timescale 1ns/100ps
module eic_channel (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic enable,
    input wire logic read_clear,
    input wire eic_pkg::eic_event_t start_sel,
    input wire eic_pkg::eic_event_t stop_sel,
    // event strobes, one bit per event code
    input wire logic [4:0] events,
    input wire logic tick,
    // sample taken by the stream
    input wire logic sample_take,
    // result
    output logic [31:0] value,
    output logic fresh
);

    eic_pkg::eic_meas_t state_q, state_d;
    logic [31:0] count_q;
    logic [31:0] value_q;
    logic fresh_q;

    wire logic start_hit = events[start_sel];
    wire logic stop_hit = events[stop_sel];
    // same edge for start and stop: one stop closes and the next opens
    wire logic stop_now = (state_q == eic_pkg::EIC_COUNTING) && stop_hit;

    // measurement sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            eic_pkg::EIC_ARMED: begin
                if (enable && start_hit) begin
                    state_d = eic_pkg::EIC_COUNTING;
                end
            end
            eic_pkg::EIC_COUNTING: begin
                if (!enable) begin
                    state_d = eic_pkg::EIC_ARMED;
                end else if (stop_hit) begin
                    state_d = (start_sel == stop_sel) ? eic_pkg::EIC_COUNTING
                                                      : eic_pkg::EIC_ARMED;
                end
            end
            default: state_d = eic_pkg::EIC_ARMED;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= eic_pkg::EIC_ARMED;
            count_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            // restart from zero on every start, count ticks while running
            if (state_d == eic_pkg::EIC_COUNTING && state_q != eic_pkg::EIC_COUNTING) begin
                count_q <= 32'h0000_0000;
            end else if (stop_now) begin
                count_q <= 32'h0000_0000;
            end else if (state_q == eic_pkg::EIC_COUNTING && tick) begin
                count_q <= count_q + 32'h0000_0001;
            end
        end
    end

    // result latch; new result wins over a read-and-clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= 32'h0000_0000;
            fresh_q <= 1'b0;
        end else if (stop_now) begin
            // the tick at the stop edge still belongs to this interval
            value_q <= count_q + {31'h0000_0000, tick};
            fresh_q <= 1'b1;
        end else if (sample_take) begin
            fresh_q <= 1'b0;
            if (read_clear) begin
                value_q <= 32'h0000_0000;
            end
        end
    end

    // without read-and-clear the old result simply stays until replaced
    assign value = value_q;
    assign fresh = fresh_q;

endmodule

/* verification/eic_top_props.sv */
/*
 * Port-level assertion checker for the edge interval counter top.
 * Assumes one clock domain and a bind placed in the bench top file.
 */
`timescale 1ns/100ps
module eic_top_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register bus
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // sequencer, clock pin and rate outputs
    input wire logic scan_start,
    input wire logic lxi7_out,
    input wire logic lxi7_oe,
    input wire logic scan_tick,
    input wire logic out_tick,
    input wire logic ref_ext,
    input wire logic strm_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // a pending request and its one-cycle answer
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_answer: assert property (s_req |=> s_ans)
        else $error("bus answer missing or too long");
    a_bus_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("bus answer without request");
    a_unmapped_zero: assert property ($fell(avs_waitrequest) && $past(avs_read)
        && $past(avs_address) > 6'h20 |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // counter words only right behind a scan start
    a_stream_scan: assert property (strm_valid |-> $past(scan_start, 2) || $past(scan_start, 3))
        else $error("counter word outside a scan");
    a_oe_ref: assert property (ref_ext |-> !lxi7_oe)
        else $error("clock driven out while external reference");
    a_drive_clock: assert property (lxi7_oe && $past(lxi7_oe) |-> lxi7_out != $past(lxi7_out))
        else $error("driven clock stuck");
    // fastest rate is forty cycles, so ticks never bunch up
    a_scan_gap: assert property (scan_tick |=> !scan_tick [*8])
        else $error("scan ticks too close");
    a_out_gap: assert property (out_tick |=> !out_tick [*8])
        else $error("output ticks too close");
endmodule

/* verification/eic_pins_model.sv */
/*
 * Tach and gate pin source: a square wave and a copy shifted by dly.
 * Assumes shape inputs change only after a clock edge.
 */
`timescale 1ns/100ps
module eic_pins_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // waveform shape in clock cycles
    input wire logic [7:0] half,
    input wire logic [7:0] dly,
    // pins toward the block
    output logic tach_in,
    output logic gate_in
);
    logic [8:0] ph;
    logic [8:0] per;
    logic [8:0] gph;

    // gate phase wraps so its edges keep a fixed offset from tach
    assign per = {half, 1'b0};
    assign gph = ph >= {1'b0, dly} ? ph - {1'b0, dly} : ph + per - {1'b0, dly};

    // phase counter; a shrunken period restarts at zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 9'h000;
            tach_in <= 1'b0;
            gate_in <= 1'b0;
        end else begin
            ph <= ph + 9'h001 >= per ? 9'h000 : ph + 9'h001;
            tach_in <= ph < {1'b0, half};
            gate_in <= gph < {1'b0, half};
        end
    end
endmodule

/* verification/edge_interval_counters_bench.sv */
/*
 * Self-checking bench for the edge interval counter block.
 * Assumes the pin model and checker files are compiled before it.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module edge_interval_counters_bench;
    logic avs_read = 1'b0, avs_write = 1'b0, conv_done = 1'b0, scan_start = 1'b0;
    logic clk, lxi7_in = 1'b0, rst_n = 1'b0, tach_in, gate_in;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, strm_data, rd;
    logic avs_waitrequest, lxi7_out, lxi7_oe, scan_tick, out_tick, ref_ext, strm_valid, strm_chan;
    logic [7:0] half = 8'h08, dly = 8'h03;
    int num_errors = 0, n_tests = 0, h, d, k, g, dv, hz, j;
    logic qc[$];
    logic [31:0] qd[$];

    eic_top u_dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .tach_in, .gate_in,
        .conv_done, .scan_start, .lxi7_in, .lxi7_out, .lxi7_oe, .scan_tick, .out_tick,
        .ref_ext, .strm_data, .strm_valid, .strm_chan);
    eic_pins_model u_pins (.clk, .rst_n, .half, .dly, .tach_in, .gate_in);

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // neighbour clock on the trigger line, never stopped
    always @(posedge clk) lxi7_in <= ~lxi7_in;
    // collect every counter word
    always @(posedge clk) if (strm_valid === 1'b1) begin
        qc.push_back(strm_chan);
        qd.push_back(strm_data);
    end

    task automatic summarize;
        $display("errors %0d in %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one access; held until the rising edge that samples waitrequest low
    task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] v,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) num_errors++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic kick(input bit s);
        @(posedge clk);
        scan_start <= s;
        conv_done <= !s;
        @(posedge clk);
        scan_start <= 1'b0;
        conv_done <= 1'b0;
    endtask

    // cycles from one tick to the next, bounded
    task automatic gap(input bit s, output int t);
        int n;
        n = 0;
        while ((s ? scan_tick : out_tick) !== 1'b1 && n < 50000) begin
            @(negedge clk);
            n++;
        end
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while ((s ? scan_tick : out_tick) !== 1'b1 && t < 50000);
    endtask

    // edge times inside one pin period
    function automatic int ev(int c);
        return c == 1 ? h : c == 2 ? 0 : c == 3 ? h + d : d;
    endfunction
    function automatic int span(int s, int p);
        int v;
        v = (ev(p) - ev(s) + 2 * h) % (2 * h);
        return v == 0 ? 2 * h : v;
    endfunction
    function automatic int divr(int f);
        int v;
        v = f == 0 ? 40000 : (40000000 + f / 2) / f;
        return v < 40 ? 40 : v;
    endfunction

    initial begin
        void'($urandom(32'h31D6));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("ref_ext", 1'b0, ref_ext);
        `CHK("lxi7_oe", 1'b0, lxi7_oe);
        // every tach and gate pairing, counter1 reversed
        for (int s = 1; s < 5; s++) begin
            for (int p = 1; p < 5; p++) begin
                h = 6 + $urandom % 15;
                d = 1 + $urandom % (h - 1);
                half <= 8'(h);
                dly <= 8'(d);
                bus(1, 6'h00, {16'h0, 3'(s), 3'(p), 2'b01, 3'(p), 3'(s), 2'b01}, rd);
                repeat (6 * h + 12) @(posedge clk);
                bus(0, 6'h18, 32'h0, rd);
                `CHK("count0", span(s, p), rd);
                bus(0, 6'h1C, 32'h0, rd);
                `CHK("count1", span(p, s), rd);
            end
        end
        // conversion to conversion, then each enable mix in the stream
        k = 5 + $urandom % 26;
        bus(1, 6'h00, 32'h0000_0101, rd);
        repeat (3) begin
            kick(0);
            repeat (k - 2) @(posedge clk);
        end
        for (int m = 0; m < 4; m++) begin
            bus(1, 6'h00, {16'h0, 7'h0, 1'(m >> 1), 7'h0, 1'(m)}, rd);
            kick(1);
            repeat (4) @(posedge clk);
            `CHK("words", (m & 1) + (m >> 1), qc.size());
            j = 0;
            for (int c = 0; c < 2; c++) begin
                if (((m >> c) & 1) == 1) begin
                    `CHK("chan", 1'(c), qc[j]);
                    `CHK("word", 32'(k), qd[j]);
                    j++;
                end
            end
            qc.delete();
            qd.delete();
        end
        // read-and-clear on counter0 only
        bus(1, 6'h00, 32'h0000_0103, rd);
        kick(1);
        repeat (4) @(posedge clk);
        bus(0, 6'h18, 32'h0, rd);
        `CHK("cleared", 32'h0, rd);
        bus(0, 6'h1C, 32'h0, rd);
        `CHK("kept", 32'(k), rd);
        // rate rounding: default, over range, random
        for (int i = 0; i < 3; i++) begin
            hz = i == 0 ? 0 : i == 1 ? 2000000 : 20000 + $urandom % 980000;
            dv = divr(hz);
            bus(1, 6'h10, 32'(hz), rd);
            bus(1, 6'h08, 32'(hz), rd);
            bus(0, 6'h0C, 32'h0, rd);
            `CHK("scan rate", (40000000 + dv / 2) / dv, rd);
            bus(0, 6'h14, 32'h0, rd);
            `CHK("out rate", (40000000 + dv / 2) / dv, rd);
        end
        gap(1, g);
        gap(1, g);
        `CHK("scan gap", dv, g);
        gap(0, g);
        gap(0, g);
        `CHK("out gap", dv, g);
        // drive-out, then external reference
        bus(1, 6'h04, 32'h0000_0002, rd);
        repeat (2) @(posedge clk);
        `CHK("drive on", 1'b1, lxi7_oe);
        bus(1, 6'h04, 32'h0000_0003, rd);
        repeat (2) @(posedge clk);
        `CHK("ext ref", 1'b1, ref_ext);
        `CHK("drive off", 1'b0, lxi7_oe);
        bus(0, 6'h24, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd);
        summarize();
    end

    // watchdog well beyond the slowest rate measurement
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        summarize();
    end
endmodule

bind eic_top eic_top_props u_props (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .scan_start, .lxi7_out, .lxi7_oe, .scan_tick,
    .out_tick, .ref_ext, .strm_valid);
